// [rtl/sfsr_pkg.sv]
// Purpose: Shared constants and types for the serial flash soft reset block
// Assumes: mclk runs at 20 MHz; SPI link is sampled by mclk
// Notes: All offsets are byte addresses on a 32-bit APB bus
package sfsr_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;            // mclk period
  localparam int T_RST_US = 30;                 // Reset recovery time
  localparam int T_SEL_US = 20;                 // Power to first select
  localparam int T_WRITE_MS = 5;                // Power to first write
  // Least times round up to whole cycles
  localparam int RST_CYC = (T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VSL_CYC = (T_SEL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUW_CYC = (T_WRITE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 10;                    // Fits RST_CYC
  localparam int PWR_W = 17;                    // Fits PUW_CYC
  localparam int BITCNT_W = 4;                  // Saturates at 9 bits

  // Opcodes
  localparam logic [7:0] OP_ARM_RESET = 8'h66;
  localparam logic [7:0] OP_EXEC_RESET = 8'h99;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [3:0] OP_BITS = 4'h8;        // Exact opcode length

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VOL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h0C;
  localparam logic [7:0] ADDR_LASTOP = 8'h10;

  // CTRL bits (write one to act)
  localparam int CTRL_OP_START = 0;
  localparam int CTRL_SUSPEND = 1;
  localparam int CTRL_OP_DONE = 2;

  // VOL field layout
  localparam int VOL_STAT_LSB = 0;
  localparam int VOL_PARAM_LSB = 8;
  localparam int VOL_WRAP_LSB = 16;
  localparam logic [7:0] VOL_STAT_RST = 8'h00;
  localparam logic [7:0] VOL_PARAM_RST = 8'h00;
  localparam logic [2:0] VOL_WRAP_RST = 3'h0;

  // STATUS bits
  localparam int STS_STATE_LSB = 0;
  localparam int STS_BUSY = 2;
  localparam int STS_SUSP = 3;
  localparam int STS_WR_LATCH = 4;
  localparam int STS_SEL_OK = 5;
  localparam int STS_WR_OK = 6;

  // EVENTS bits
  localparam int EV_W = 5;
  localparam int EV_RESET_DONE = 0;
  localparam int EV_REJECTED = 1;
  localparam int EV_CORRUPT = 2;
  localparam int EV_EARLY_SEL = 3;
  localparam int EV_WR_INHIBIT = 4;

  // Reset sequencer states, Gray along idle, armed, recover
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RECOVER = 2'b11
  } sfsr_state_t;

  // Opcode match on a complete eight-bit frame
  function automatic logic sfsr_is_op(input logic [7:0] code, input logic len_ok, input logic [7:0] want);
    sfsr_is_op = len_ok && (code == want);
  endfunction : sfsr_is_op

endpackage : sfsr_pkg

// [rtl/sfsr_op_if.sv]
// Purpose: Carries decoded SPI frames from the receiver to the core
// Assumes: All signals are on mclk
// Notes: frame_end and frame_start are one-cycle pulses
`timescale 1ns/1ns
interface sfsr_op_if;
  logic frame_start;        // Chip select went low
  logic frame_end;          // Chip select went high
  logic [7:0] op_byte;      // First eight bits of the frame
  logic len_ok;             // Exactly eight bits were clocked
  modport rx (output frame_start, frame_end, op_byte, len_ok);
  modport core (input frame_start, frame_end, op_byte, len_ok);
endinterface : sfsr_op_if

// [rtl/sfsr_timer.sv]
// Purpose: Down counter for the reset recovery interval
// Assumes: load is a one-cycle pulse
// Notes: running stays high for exactly RST_CYC cycles after load
`timescale 1ns/1ns
module sfsr_timer
  import sfsr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  // Status
  output logic running,
  output logic done
);

  logic [TMR_W-1:0] cnt_reg;   // Cycles left
  logic [TMR_W-1:0] cnt_next;

  // Reload wins over counting
  assign cnt_next = load ? TMR_W'(RST_CYC) : (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign running = (cnt_reg != '0);
  assign done = (cnt_reg == TMR_W'(1)) && !load;

  // Counter register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : sfsr_timer

// [rtl/sfsr_spi_rx.sv]
// Purpose: Samples SPI pins on mclk and frames opcode bytes
// Assumes: sclk is far slower than mclk (mode 0, data taken on rising edge)
// Notes: Each pin passes three flip-flops before use
`timescale 1ns/1ns
module sfsr_spi_rx
  import sfsr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // SPI pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  // Frames to core
  sfsr_op_if.rx op
);

  logic [2:0] sclk_sync_reg;   // [0] is read only by [1]
  logic [2:0] cs_sync_reg;
  logic [2:0] mosi_sync_reg;
  logic sclk_st_reg;           // Filtered levels
  logic cs_st_reg;
  logic mosi_st_reg;
  logic [7:0] shift_reg;       // Opcode shifter
  logic [BITCNT_W-1:0] cnt_reg;
  logic start_reg;
  logic end_reg;
  logic [7:0] byte_reg;
  logic len_reg;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;

  // A level counts once stages two and three agree
  assign sclk_rise = (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2] && !sclk_st_reg;
  assign cs_fall = (cs_sync_reg[1] == cs_sync_reg[2]) && !cs_sync_reg[2] && cs_st_reg;
  assign cs_rise = (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2] && !cs_st_reg;

  // Synchronisers and filtered levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      mosi_sync_reg <= 3'h0;
      sclk_st_reg <= 1'b0;
      cs_st_reg <= 1'b1;
      mosi_st_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      mosi_sync_reg <= {mosi_sync_reg[1:0], mosi};
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_st_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_st_reg <= cs_sync_reg[2];
      if (mosi_sync_reg[1] == mosi_sync_reg[2]) mosi_st_reg <= mosi_sync_reg[2];
    end
  end

  // Shift bits on rising sclk while selected; count saturates past eight
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
      cnt_reg <= '0;
    end else if (cs_fall) begin
      cnt_reg <= '0;
    end else if (sclk_rise && !cs_st_reg) begin
      if (cnt_reg < BITCNT_W'(OP_BITS)) shift_reg <= {shift_reg[6:0], mosi_st_reg};
      if (cnt_reg <= BITCNT_W'(OP_BITS)) cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Frame pulses; length judged at deselect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      end_reg <= 1'b0;
      byte_reg <= 8'h00;
      len_reg <= 1'b0;
    end else begin
      start_reg <= cs_fall;
      end_reg <= cs_rise;
      if (cs_rise) begin
        byte_reg <= shift_reg;
        len_reg <= (cnt_reg == BITCNT_W'(OP_BITS));
      end
    end
  end

  assign op.frame_start = start_reg;
  assign op.frame_end = end_reg;
  assign op.op_byte = byte_reg;
  assign op.len_ok = len_reg;

endmodule : sfsr_spi_rx

// [rtl/sfsr_core.sv]
// Purpose: Soft reset sequencer of a serial flash with APB status and control
// Assumes: SPI pins sampled on mclk; APB slave with zero wait states
// Notes: Each rule is tagged where the logic keeps it
`timescale 1ns/1ns
module sfsr_core
  import sfsr_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC  // Power-up write delay in cycles
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // SPI pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device status
  output logic in_recovery,
  output logic abort_ops
);

  sfsr_op_if op_bus();               // Receiver to core frames

  // Sequencer and device state
  sfsr_state_t state_reg;            // Sequencer state
  sfsr_state_t state_next;
  logic busy_reg;                    // Internal operation running
  logic suspend_flag_reg;            // Operation suspended
  logic write_enable_latch_reg;      // Write enable latch
  logic [7:0] vol_stat_reg;          // Volatile status bits
  logic [7:0] read_param_field_reg;  // Read parameter setting
  logic [2:0] wrap_setting_field_reg; // Wrap setting

  // Software-visible bookkeeping
  logic [EV_W-1:0] ev_reg;           // Sticky events, write one to clear
  logic [EV_W-1:0] ev_next;
  logic [EV_W-1:0] ev_set;
  logic [7:0] last_op_reg;           // Last accepted opcode
  logic [7:0] rst_cnt_reg;           // Accepted resets, wraps
  logic [PWR_W-1:0] pwr_cnt_reg;     // Time since power-up, saturates
  logic seen_select_reg;             // First select already seen
  logic abort_reg;
  logic recov_reg;
  logic [31:0] prdata_reg;

  // Recovery timer handshake
  logic tmr_load;
  logic tmr_running;
  logic tmr_done;

  // Frame decode
  logic frame_end;
  logic is_arm;
  logic is_exec;
  logic is_wren;
  logic is_wrdi;
  logic reset_accept;
  logic rejected;
  logic select_ok;
  logic write_ok;

  // APB decode
  logic apb_setup;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_vol;
  logic hit_status;
  logic hit_events;
  logic hit_lastop;
  logic mapped;
  logic [31:0] rd_mux;

  // SPI receiver
  // Frames land about four mclk after deselect
  sfsr_spi_rx u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .op(op_bus)
  );

  // Recovery timer
  // Loaded by the accept pulse
  sfsr_timer u_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(tmr_load),
    .running(tmr_running),
    .done(tmr_done)
  );

  // Opcode matches need an exact eight-bit frame
  // One frame per deselect
  assign frame_end = op_bus.frame_end;
  assign is_arm = sfsr_is_op(op_bus.op_byte, op_bus.len_ok, OP_ARM_RESET);
  assign is_exec = sfsr_is_op(op_bus.op_byte, op_bus.len_ok, OP_EXEC_RESET);
  // Write enable and disable, same framing
  assign is_wren = sfsr_is_op(op_bus.op_byte, op_bus.len_ok, OP_WRITE_ENABLE);
  assign is_wrdi = sfsr_is_op(op_bus.op_byte, op_bus.len_ok, OP_WRITE_DISABLE);

  // Execute only counts straight after arm
  assign reset_accept = (state_reg == ST_ARMED) && frame_end && is_exec;
  // Anything arriving while recovering is dropped; the timer
  // covers the same span and guards against a state upset
  assign rejected = (state_reg == ST_RECOVER || tmr_running) && frame_end;
  assign tmr_load = reset_accept;

  // Power-up windows seen from the device side
  // Limitation: the first early select is flagged, never blocked; an early write enable is flagged and refused
  assign select_ok = (pwr_cnt_reg >= PWR_W'(VSL_CYC));
  assign write_ok = (pwr_cnt_reg >= PWR_W'(PUW_CYCLES));

  // Sequencer next state
  // Holds by default, so every path assigns
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Only a complete arming frame leaves idle
        if (frame_end && is_arm) state_next = ST_ARMED;
      end
      ST_ARMED: begin
        // Any other frame, a second arm included, disarms
        if (frame_end) state_next = is_exec ? ST_RECOVER : ST_IDLE;
      end
      ST_RECOVER: begin
        // Frames ignored until the timer runs out
        if (tmr_done) state_next = ST_IDLE;
      end
      default: begin
        // Unused code falls back to idle
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  // Gray codes keep idle to armed and armed to recover one bit apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-up counter; saturates so it never wraps back to unsafe
  // rst_n stands in for power-up here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_reg <= '0;
      seen_select_reg <= 1'b0;
    end else begin
      if (!write_ok || !select_ok) pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
      // First select since release
      if (op_bus.frame_start) seen_select_reg <= 1'b1;
    end
  end

  // APB decode; zero wait states
  // All eight address bits are decoded
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_vol = (paddr == ADDR_VOL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_events = (paddr == ADDR_EVENTS);
  assign hit_lastop = (paddr == ADDR_LASTOP);
  // Five registers, one aligned word each
  assign mapped = hit_ctrl || hit_vol || hit_status || hit_events || hit_lastop;
  // One-cycle access, so pready is tied high
  assign pready = 1'b1;
  // Unmapped offsets error in the access cycle
  assign pslverr = psel && penable && !mapped;

  // Internal operation model: software starts, suspends, finishes
  // Stands in for erase and program
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      suspend_flag_reg <= 1'b0;
    end else if (reset_accept) begin
      // Abort wins over any software request that cycle
      busy_reg <= 1'b0;
      suspend_flag_reg <= 1'b0;
    end else if (apb_wr && hit_ctrl) begin
      // Bits may share one write; done wins
      if (pwdata[CTRL_OP_START]) busy_reg <= 1'b1;
      if (pwdata[CTRL_SUSPEND] && busy_reg) suspend_flag_reg <= 1'b1;
      // Done ends the operation and any suspension
      if (pwdata[CTRL_OP_DONE]) begin
        busy_reg <= 1'b0;
        suspend_flag_reg <= 1'b0;
      end
    end
  end

  // Volatile settings; an accepted reset restores defaults
  // Non-volatile bits are not held here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vol_stat_reg <= VOL_STAT_RST;
      read_param_field_reg <= VOL_PARAM_RST;
      wrap_setting_field_reg <= VOL_WRAP_RST;
    end else if (reset_accept) begin
      vol_stat_reg <= VOL_STAT_RST;
      read_param_field_reg <= VOL_PARAM_RST;
      wrap_setting_field_reg <= VOL_WRAP_RST;
    end else if (apb_wr && hit_vol) begin
      // One write sets all three fields
      vol_stat_reg <= pwdata[VOL_STAT_LSB +: 8];
      read_param_field_reg <= pwdata[VOL_PARAM_LSB +: 8];
      wrap_setting_field_reg <= pwdata[VOL_WRAP_LSB +: 3];
    end
  end

  // Write enable latch from SPI; inhibited early after power-up
  // Reset clearing comes first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch_reg <= 1'b0;
    end else if (reset_accept) begin
      write_enable_latch_reg <= 1'b0;
    end else if (frame_end && state_reg != ST_RECOVER) begin
      // Enable needs the write window; disable works at any time outside recovery
      if (is_wren && write_ok) write_enable_latch_reg <= 1'b1;
      if (is_wrdi) write_enable_latch_reg <= 1'b0;
    end
  end

  // Event sources; set wins over a same-cycle clear
  // Each source is a one-cycle pulse
  always_comb begin
    ev_set = '0;
    // Recovery ran its full length
    ev_set[EV_RESET_DONE] = tmr_done;
    ev_set[EV_REJECTED] = rejected;
    // Data integrity is not guaranteed; flag it for software
    ev_set[EV_CORRUPT] = reset_accept && (busy_reg || suspend_flag_reg);
    // Host broke its power-up waits
    ev_set[EV_EARLY_SEL] = op_bus.frame_start && !seen_select_reg && !select_ok;
    ev_set[EV_WR_INHIBIT] = frame_end && is_wren && !write_ok && state_reg != ST_RECOVER;
  end
  assign ev_next = (ev_reg & ~((apb_wr && hit_events) ? pwdata[EV_W-1:0] : '0)) | ev_set;

  // Events, last opcode, reset count and pin registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_reg <= '0;
      last_op_reg <= 8'h00;
      rst_cnt_reg <= 8'h00;
      abort_reg <= 1'b0;
      recov_reg <= 1'b0;
    end else begin
      // Set and clear merged in ev_next
      ev_reg <= ev_next;
      // Complete frames outside recovery only
      if (frame_end && op_bus.len_ok && !rejected) last_op_reg <= op_bus.op_byte;
      // Count wraps at 256
      if (reset_accept) rst_cnt_reg <= rst_cnt_reg + 1'b1;
      // Registered so the pins never glitch
      abort_reg <= reset_accept;
      recov_reg <= (state_next == ST_RECOVER);
    end
  end

  // Read mux; unmapped and write-only read as zero
  // CTRL is write only, so it has no branch
  assign rd_mux = hit_vol ? {13'h0000, wrap_setting_field_reg, read_param_field_reg, vol_stat_reg} :
                  hit_status ? {25'h0000000, write_ok, select_ok, write_enable_latch_reg,
                                suspend_flag_reg, busy_reg, state_reg} :
                  hit_events ? {27'h0000000, ev_reg} :
                  hit_lastop ? {16'h0000, rst_cnt_reg, last_op_reg} :
                  32'h00000000;

  // Read data captured in the setup cycle, valid in the access cycle
  // Trade-off: registered data, one cycle stale
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign in_recovery = recov_reg;
  assign abort_ops = abort_reg;

endmodule : sfsr_core

// [rtl/placeholder_unused.sv]
`timescale 1ns/1ns

// [tb/sfsr_core_properties.sv]
// Purpose: Port-level assertions for the soft reset sequencer
// Assumes: One mclk domain; rst_n asynchronous, active low
// Notes: Bound into every sfsr_core instance after the module
`timescale 1ns/1ns
module sfsr_core_properties
  import sfsr_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC  // Mirrors the design parameter
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // SPI pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device status
  input wire logic in_recovery,
  input wire logic abort_ops
);
  localparam int REC_CYC = RST_CYC;  // Recovery length in cycles
  logic [9:0] rcnt_reg;  // Cycles spent in recovery so far
  logic [9:0] rcnt_next;
  logic mapped;  // Address hits one of the five registers
  assign rcnt_next = in_recovery ? rcnt_reg + 10'h001 : 10'h000;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_VOL, ADDR_STATUS, ADDR_EVENTS, ADDR_LASTOP};
  // Recovery counter; a repetition of 600 would be far too slow to unroll
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_reg <= 10'h000;
    end else begin
      rcnt_reg <= rcnt_next;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Accepted reset: abort pulse and recovery start in one cycle
  sequence s_accept;
    $rose(abort_ops) ##0 $rose(in_recovery);
  endsequence
  // Read of the volatile fields while recovery runs
  sequence s_vol_read;
    psel && !penable && !pwrite && paddr == ADDR_VOL && in_recovery ##1 psel && penable;
  endsequence
  AST_ABORT_START: assert property ($rose(abort_ops) |-> s_accept)
    else $error("abort pulse without recovery start");
  AST_ABORT_PULSE: assert property (s_accept |=> !abort_ops [*8])
    else $error("abort pulse not single");
  AST_REC_LEN: assert property ($fell(in_recovery) |-> rcnt_reg == REC_CYC)
    else $error("recovery length wrong");
  AST_REC_MAX: assert property (in_recovery |-> rcnt_reg < REC_CYC)
    else $error("recovery overran");
  AST_NO_REACCEPT: assert property (in_recovery && $past(in_recovery) |-> !abort_ops)
    else $error("reset accepted during recovery");
  AST_ABORT_DESEL: assert property (abort_ops |-> cs_n && $past(cs_n, 3))
    else $error("reset accepted before deselect");
  AST_VOL_CLEARED: assert property (s_vol_read |-> prdata == 32'h00000000)
    else $error("volatile fields not cleared");
  AST_APB_ANSWER: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("bad APB answer");
endmodule : sfsr_core_properties

bind sfsr_core sfsr_core_properties #(.PUW_CYCLES(PUW_CYCLES)) prop_u (
  .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_recovery(in_recovery), .abort_ops(abort_ops)
);

// [tb/sfsr_spi_host.sv]
// Purpose: Behavioural SPI host sending opcode frames
// Assumes: Mode 0, MSB first, clock idles low between frames
// Notes: Link timing runs free of mclk; hp sets host speed
`timescale 1ns/1ns
module sfsr_spi_host (
  // SPI pins
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // Deselected bus at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame of nb bits, hp ns per clock phase
  task automatic send(input logic [15:0] bits, input int nb, input int hp);
    #12;  // Keep pin changes off the mclk edges
    cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi = bits[i];  // Set while clock low, taken on rise
      #hp sclk = 1'b1;
      #hp sclk = 1'b0;
    end
    #hp cs_n = 1'b1;  // Frame counts only on deselect
    mosi = ~mosi;  // Released line must not keep its last bit
    #(4 * hp);  // Deselect time before the next frame
  endtask : send
endmodule : sfsr_spi_host

// [tb/testbench.sv]
// Purpose: Self-checking bench for the soft reset sequencer
// Assumes: 20 MHz mclk, SPI host at 400 ns link period
// Notes: A bench model predicts every register read
`timescale 1ns/1ns
module testbench;
  import sfsr_pkg::*;
  localparam int PUW = 1000;  // Shortened power-up write delay
  logic mclk, rst_n, sclk, cs_n, mosi, psel, penable, pwrite, pready, pslverr, in_recovery, abort_ops;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0, compares = 0, n_abort = 0;
  integer seed = 32'hBDBF042D;
  // Model state
  logic m_busy, m_susp, m_wel, m_sel, m_wr;
  logic [1:0] m_st;
  logic [7:0] m_last;
  logic [31:0] m_vol;
  int m_ev, m_rst, m_seen;

  sfsr_core #(.PUW_CYCLES(PUW)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_recovery(in_recovery), .abort_ops(abort_ops)
  );
  sfsr_spi_host host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Count abort pulses at the port
  always @(posedge mclk) begin
    if (abort_ops === 1'b1) n_abort++;
  end
  // Watchdog, well beyond the expected run
  initial begin
    #2000000;
    n_errors++;
    $display("ERROR %0t timeout", $time);
    summarize();
  end

  task automatic summarize();
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) chk(32'h1, 32'h0, "apb hang");
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Register write plus model update
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
    if (a == ADDR_VOL) m_vol = d & 32'h0007FFFF;
    if (a == ADDR_EVENTS) m_ev = m_ev & ~d;
    if (a == ADDR_CTRL && d[CTRL_OP_START]) m_busy = 1'b1;
    if (a == ADDR_CTRL && d[CTRL_SUSPEND] && m_busy) m_susp = 1'b1;
    if (a == ADDR_CTRL && d[CTRL_OP_DONE]) {m_busy, m_susp} = 2'b00;
  endtask : wr

  // Send a frame, let it land, then predict its effect
  task automatic frame(input logic [15:0] b, input int nb, input int hp);
    host_u.send(b, nb, hp);
    repeat (10) @(posedge mclk);
    if (m_seen == 0 && !m_sel) m_ev |= 8;  // First select too early
    m_seen = 1;
    if (m_st == 2'h3) begin
      m_ev |= 2;  // Refused during recovery
    end else if (nb != 8) begin
      m_st = 2'h0;  // Bad length counts as another instruction
    end else begin
      m_last = b[7:0];
      if (m_st == 2'h1 && b[7:0] == OP_EXEC_RESET) begin
        if (m_busy || m_susp) m_ev |= 4;
        {m_busy, m_susp, m_wel, m_st, m_vol} = {5'b00011, 32'h0};
        m_rst++;
      end else begin
        m_st = (m_st == 2'h0 && b[7:0] == OP_ARM_RESET) ? 2'h1 : 2'h0;
      end
      if (b[7:0] == OP_WRITE_ENABLE && m_wr) m_wel = 1'b1;
      if (b[7:0] == OP_WRITE_ENABLE && !m_wr) m_ev |= 16;  // Write enable too early
      if (b[7:0] == OP_WRITE_DISABLE) m_wel = 1'b0;
    end
  endtask : frame

  // Bounded wait for the end of recovery
  task automatic wait_rec();
    int k;
    k = 0;
    while (in_recovery !== 1'b0 && k < 700) begin
      @(posedge mclk);
      k++;
    end
    chk({31'h0, in_recovery}, 32'h0, "recovery end");
    m_st = 2'h0;
    m_ev |= 1;
    repeat (2) @(posedge mclk);
  endtask : wait_rec

  // Compare all readable registers with the model
  task automatic check_all();
    logic [31:0] rd;
    logic e;
    apb(1'b0, ADDR_VOL, 32'h0, rd, e);
    chk(rd, m_vol, "vol");
    apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
    chk(rd, {25'h0, m_wr, m_sel, m_wel, m_susp, m_busy, m_st}, "status");
    apb(1'b0, ADDR_EVENTS, 32'h0, rd, e);
    chk(rd, m_ev, "events");
    apb(1'b0, ADDR_LASTOP, 32'h0, rd, e);
    chk(rd, {16'h0, m_rst[7:0], m_last}, "lastop");
    chk(n_abort, m_rst, "abort pulses");
  endtask : check_all

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic e;
    logic [15:0] oth_q[$];
    int len_q[$];
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {m_busy, m_susp, m_wel, m_sel, m_wr, m_st, m_last, m_vol} = '0;
    {m_ev, m_rst, m_seen} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    check_all();
    apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    repeat (PUW + 100) @(posedge mclk);  // Host waits before select and write
    {m_sel, m_wr} = 2'b11;
    // Reset while an operation is suspended
    wr(ADDR_VOL, $random(seed));
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    frame(OP_WRITE_ENABLE, 8, 200);
    check_all();  // Busy and suspend read first
    frame(OP_ARM_RESET, 8, 200);
    frame(OP_EXEC_RESET, 8, 200);
    frame(OP_ARM_RESET, 8, 200);
    check_all();
    wait_rec();
    check_all();
    // Anything between arm and execute disarms
    oth_q = '{16'h0004, 16'h0066, 16'h0133, 16'h004C};
    len_q = '{8, 8, 9, 7};
    foreach (oth_q[i]) begin
      frame(OP_ARM_RESET, 8, 200);
      frame(oth_q[i], len_q[i], 200);
      frame(OP_EXEC_RESET, 8, 200);
      check_all();
    end
    // Reset of an idle device
    frame(OP_ARM_RESET, 8, 200);
    check_all();
    frame(OP_EXEC_RESET, 8, 200);
    wait_rec();
    wr(ADDR_STATUS, 32'hFFFFFFFF);
    wr(ADDR_EVENTS, 32'hFFFFFFFF);
    check_all();
    // Reset again mid-run; an early select and write enable get flagged
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    {m_busy, m_susp, m_wel, m_sel, m_wr, m_st, m_last, m_vol} = '0;
    {m_ev, m_rst, m_seen, n_abort} = '0;
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    frame(OP_WRITE_ENABLE, 8, 200);
    check_all();
    summarize();
  end
endmodule : testbench
